// ---- hw/bdr_readout_port.v ----
`timescale 1ns/100ps
`include "bdr_consts.vh"

module bdr_readout_port #(
    parameter FULL_COUNT  = `BDR_FULL_SMALL,
    parameter CONV_MS     = `BDR_CONV_MS_SMALL,
    parameter CNT_W       = 22,
    parameter CONV_CYCLES = CONV_MS * `BDR_CLK_KHZ
) (
    input  wire                     clk_sys,
    input  wire                     rst,
    // avalon-mm slave
    input  wire [`BDR_ADDR_W-1:0]   avs_address,
    input  wire                     avs_read,
    input  wire                     avs_write,
    input  wire [`BDR_DATA_W-1:0]   avs_writedata,
    input  wire [3:0]               avs_byteenable,
    output reg  [`BDR_DATA_W-1:0]   avs_readdata,
    output wire                     avs_waitrequest,
    // measurement core, same clock
    input  wire [`BDR_BIN_W-1:0]    core_count,
    input  wire                     core_negative,
    input  wire                     core_over,
    // host pins
    input  wire                     conversion_go,
    input  wire                     digit_select_latch_en,
    input  wire [1:0]               digit_addr,
    output reg  [`BDR_DIGIT_W-1:0]  digit_data,
    output reg                      sign_pos,
    output reg                      range_exceeded,
    output reg                      conversion_done
);
    localparam integer PERIOD_LAST_I   = CONV_CYCLES - 1;
    localparam integer STEPS_I         = `BDR_BIN_W;
    localparam [CNT_W-1:0] PERIOD_LAST = PERIOD_LAST_I[CNT_W-1:0];
    localparam [`BDR_BIN_W-1:0] FULL   = FULL_COUNT[`BDR_BIN_W-1:0];
    localparam [`BDR_STEP_W-1:0] STEPS = STEPS_I[`BDR_STEP_W-1:0];

    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_CONV = 2'b01;
    localparam [1:0] ST_LOAD = 2'b10;

    // synchronised pins
    wire [3:0] pins_raw = {digit_addr, digit_select_latch_en, conversion_go};
    wire [3:0] pins;
    wire       go_lvl   = pins[0];
    wire       le_lvl   = pins[1];
    wire [1:0] addr_lvl = pins[3:2];

    bdr_pin_sync #(
        .W      (4)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .rst    (rst),
        .pin    (pins_raw),
        .level  (pins)
    );

    reg                     go_prev;
    reg                     le_prev;
    reg  [1:0]              addr_held;
    reg  [CNT_W-1:0]        period_cnt;
    reg                     armed;
    reg  [1:0]              state;
    reg  [`BDR_STEP_W-1:0]  step;
    reg  [`BDR_BIN_W-1:0]   bin_sh;
    reg  [`BDR_BCD_W-1:0]   bcd_sh;
    reg                     cap_neg;
    reg                     cap_over;
    reg  [`BDR_BCD_W-1:0]   bcd_out;
    reg                     ctrl_cont;
    reg                     sw_start;
    reg                     bus_ack;
    reg  [`BDR_BCD_W-1:0]   next_bcd;
    reg  [`BDR_DIGIT_W-1:0] next_digit;
    reg  [`BDR_DIGIT_W-1:0] nib;
    reg  [`BDR_DATA_W-1:0]  next_readdata;
    integer                 k;

    wire       period_end = (period_cnt == PERIOD_LAST);
    wire       go_rise    = go_lvl & ~go_prev;
    wire       go_held    = go_lvl | ctrl_cont;
    wire       start_req  = go_rise | sw_start;
    wire       le_rise    = le_lvl & ~le_prev;
    // capture cycle uses the incoming address so no stale digit shows
    wire [1:0] addr_eff   = le_lvl ? (le_rise ? addr_lvl : addr_held) : addr_lvl;
    wire       bus_req    = avs_read | avs_write;

    // one wait cycle, answer on the second edge
    assign avs_waitrequest = bus_req & ~bus_ack;

    // free-running measurement period
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            period_cnt <= {CNT_W{1'b0}};
        end else if (period_end) begin
            period_cnt <= {CNT_W{1'b0}};
        end else begin
            period_cnt <= period_cnt + 1'b1;
        end
    end

    // digit address: flow through when low, captured on rising enable
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            le_prev   <= 1'b0;
            addr_held <= 2'b00;
        end else begin
            le_prev <= le_lvl;
            if (le_rise) begin
                addr_held <= addr_lvl;
            end
        end
    end

    // double dabble step
    always @* begin
        next_bcd = bcd_sh;
        for (k = 0; k < 4; k = k + 1) begin
            nib = bcd_sh[k*4 +: 4];
            if (nib >= `BDR_ADD3_LIMIT) begin
                nib = nib + `BDR_ADD3;
            end
            next_bcd[k*4 +: 4] = nib;
        end
        next_bcd = {next_bcd[`BDR_BCD_W-2:0], bin_sh[`BDR_BIN_W-1]};
    end

    // start, capture, convert and transfer
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            go_prev         <= 1'b0;
            armed           <= 1'b0;
            state           <= ST_IDLE;
            step            <= {`BDR_STEP_W{1'b0}};
            bin_sh          <= {`BDR_BIN_W{1'b0}};
            bcd_sh          <= {`BDR_BCD_W{1'b0}};
            cap_neg         <= 1'b0;
            cap_over        <= 1'b0;
            bcd_out         <= {`BDR_BCD_W{1'b0}};
            sign_pos        <= `BDR_SIGN_POS;
            range_exceeded  <= 1'b0;
            conversion_done <= 1'b0;
        end else begin
            go_prev <= go_lvl;
            case (state)
                ST_IDLE: begin
                    if (period_end && (armed || go_held)) begin
                        bin_sh   <= core_count;
                        bcd_sh   <= {`BDR_BCD_W{1'b0}};
                        cap_neg  <= core_negative;
                        cap_over <= core_over | (core_count >= FULL);
                        step     <= {`BDR_STEP_W{1'b0}};
                        state    <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    bcd_sh <= next_bcd;
                    bin_sh <= {bin_sh[`BDR_BIN_W-2:0], 1'b0};
                    step   <= step + 1'b1;
                    if (step == STEPS - 1'b1) begin
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (cap_over) begin
                        bcd_out <= {4{`BDR_OVER_DIGIT}};
                    end else begin
                        bcd_out <= bcd_sh;
                    end
                    range_exceeded  <= cap_over;
                    sign_pos        <= ~cap_neg;
                    conversion_done <= 1'b1;
                    state           <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            // a start in the loading cycle still wins and re-arms
            if (start_req) begin
                armed           <= 1'b1;
                conversion_done <= 1'b0;
            end else if (state == ST_LOAD) begin
                armed <= 1'b0;
            end
        end
    end

    // digit port mux
    always @* begin
        case (addr_eff)
            2'd0:    next_digit = bcd_out[3:0];
            2'd1:    next_digit = bcd_out[7:4];
            2'd2:    next_digit = bcd_out[11:8];
            2'd3:    next_digit = bcd_out[15:12];
            default: next_digit = bcd_out[3:0];
        endcase
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            digit_data <= {`BDR_DIGIT_W{1'b0}};
        end else begin
            digit_data <= next_digit;
        end
    end

    // register read data
    always @* begin
        next_readdata = {`BDR_DATA_W{1'b0}};
        case (avs_address)
            `BDR_OFS_DIGIT1: next_readdata[3:0] = bcd_out[3:0];
            `BDR_OFS_DIGIT2: next_readdata[3:0] = bcd_out[7:4];
            `BDR_OFS_DIGIT3: next_readdata[3:0] = bcd_out[11:8];
            `BDR_OFS_DIGIT4: begin
                next_readdata[3:0]             = bcd_out[15:12];
                next_readdata[7:4]             = {1'b0, range_exceeded, sign_pos, 1'b0};
            end
            `BDR_OFS_STATUS: begin
                next_readdata[`BDR_STAT_DONE]  = conversion_done;
                next_readdata[`BDR_STAT_SIGN]  = sign_pos;
                next_readdata[`BDR_STAT_OVER]  = range_exceeded;
                next_readdata[`BDR_STAT_ARMED] = armed;
            end
            `BDR_OFS_CTRL: next_readdata[`BDR_CTRL_CONT] = ctrl_cont;
            default: next_readdata = {`BDR_DATA_W{1'b0}};
        endcase
    end

    // avalon slave
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bus_ack      <= 1'b0;
            avs_readdata <= {`BDR_DATA_W{1'b0}};
            ctrl_cont    <= 1'b0;
            sw_start     <= 1'b0;
        end else begin
            sw_start <= 1'b0;
            bus_ack  <= bus_req & ~bus_ack;
            if (bus_req && !bus_ack) begin
                avs_readdata <= avs_read ? next_readdata : {`BDR_DATA_W{1'b0}};
            end
            if (avs_write && bus_ack && avs_byteenable[0] &&
                avs_address == `BDR_OFS_CTRL) begin
                ctrl_cont <= avs_writedata[`BDR_CTRL_CONT];
                sw_start  <= avs_writedata[`BDR_CTRL_START];
            end
        end
    end
endmodule

// ---- shared/bdr_consts.vh ----
`ifndef BDR_CONSTS_VH
`define BDR_CONSTS_VH

// clock and conversion timing, full-scale counts
`define BDR_CLK_KHZ         10000
`define BDR_CONV_MS_SMALL   200
`define BDR_CONV_MS_LARGE   400
`define BDR_FULL_SMALL      2000
`define BDR_FULL_LARGE      4000

// widths
`define BDR_BIN_W           12
`define BDR_BCD_W           16
`define BDR_DIGIT_W         4
`define BDR_ADDR_W          5
`define BDR_DATA_W          32
`define BDR_STEP_W          4

// register byte offsets
`define BDR_OFS_DIGIT1      5'h00
`define BDR_OFS_DIGIT2      5'h04
`define BDR_OFS_DIGIT3      5'h08
`define BDR_OFS_DIGIT4      5'h0c
`define BDR_OFS_STATUS      5'h10
`define BDR_OFS_CTRL        5'h14

// control fields
`define BDR_CTRL_START      0
`define BDR_CTRL_CONT       1

// status fields
`define BDR_STAT_DONE       0
`define BDR_STAT_SIGN       1
`define BDR_STAT_OVER       2
`define BDR_STAT_ARMED      3

// codes and reset values
`define BDR_OVER_DIGIT      4'he
`define BDR_ADD3_LIMIT      4'h5
`define BDR_ADD3            4'h3
`define BDR_SIGN_POS        1'b1

`endif

// ---- hw/bdr_pin_sync.v ----
`timescale 1ns/100ps
// three-stage pin synchroniser; output moves only when stages two and three agree
module bdr_pin_sync #(
    parameter W = 1
) (
    input  wire         clk_sys,
    input  wire         rst,
    input  wire [W-1:0] pin,
    output reg  [W-1:0] level
);
    reg [W-1:0] stage1;
    reg [W-1:0] stage2;
    reg [W-1:0] stage3;
    integer     i;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage1 <= {W{1'b0}};
            stage2 <= {W{1'b0}};
            stage3 <= {W{1'b0}};
            level  <= {W{1'b0}};
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            for (i = 0; i < W; i = i + 1) begin
                if (stage2[i] == stage3[i]) begin
                    level[i] <= stage3[i];
                end
            end
        end
    end
endmodule

// ---- verification/bdr_readout_port_sva.sv ----
`timescale 1ns/100ps
`include "bdr_consts.vh"
module bdr_readout_port_sva (
    input wire        clk_sys,
    input wire        rst,
    input wire [4:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire        conversion_go,
    input wire [3:0]  digit_data,
    input wire        range_exceeded,
    input wire        conversion_done
);
    reg       go_d;
    reg [3:0] since;
    wire      req = avs_read | avs_write;
    wire      rdy = req & ~avs_waitrequest;
    wire      sw_go = rdy & avs_write & avs_byteenable[0] & avs_writedata[0]
                      & (avs_address == `BDR_OFS_CTRL);
    // cycles since the last start request, saturating
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            go_d <= 1'b0;
            since <= 4'hf;
        end else begin
            go_d <= conversion_go;
            if ((conversion_go & ~go_d) | sw_go)
                since <= 4'h0;
            else if (since != 4'hf)
                since <= since + 4'h1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("no wait state on new request");
    a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait");
    a_rd_unmapped: assert property (rdy && avs_read && avs_address > `BDR_OFS_CTRL
        |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_rd_msd: assert property (rdy && avs_read && avs_address == `BDR_OFS_DIGIT4
        |-> avs_readdata[31:7] == 25'h0 && !avs_readdata[4])
        else $error("top digit word has stray bits");
    a_ovr_digit: assert property (range_exceeded && $past(range_exceeded)
        |-> digit_data == `BDR_OVER_DIGIT)
        else $error("digit not e during overrange");
    a_done_falls: assert property ($rose(conversion_go) |-> ##[1:8] !conversion_done)
        else $error("done not low after start pin");
    a_done_sw: assert property (sw_go |-> ##[1:3] !conversion_done)
        else $error("done not low after start write");
    a_done_cause: assert property ($fell(conversion_done) |-> since < 4'h8)
        else $error("done fell without start");
endmodule

// ---- verification/bdr_host_model.sv ----
`timescale 1ns/100ps
module bdr_host_model (
    input  wire       clk_sys,
    input  wire       conversion_done,
    input  wire [3:0] digit_data,
    output reg        conversion_go,
    output reg        digit_select_latch_en,
    output reg  [1:0] digit_addr
);
    initial begin
        conversion_go = 1'b0;
        digit_select_latch_en = 1'b0;
        digit_addr = 2'h0;
    end
    // called just after a rising edge; leaves time for the pin synchroniser
    task pins(input g, input le, input [1:0] a);
        begin
            conversion_go <= g;
            digit_select_latch_en <= le;
            digit_addr <= a;
            repeat (8) @(posedge clk_sys);
        end
    endtask
    task start;
        begin
            pins(1'b1, 1'b0, digit_addr);
            pins(1'b0, 1'b0, digit_addr);
        end
    endtask
    // top digit first, flow-through addressing
    task read_digits(output [15:0] v);
        integer i;
        begin
            for (i = 3; i >= 0; i = i - 1) begin
                pins(conversion_go, 1'b0, i[1:0]);
                v[i*4 +: 4] = digit_data;
            end
        end
    endtask
    // polling host waits past the longest start-to-done delay
    task wait_done(output ok);
        integer n;
        begin
            n = 0;
            while (conversion_done !== 1'b1 && n < 300) begin
                @(posedge clk_sys);
                n = n + 1;
            end
            ok = (conversion_done === 1'b1);
        end
    endtask
endmodule

// ---- verification/bdr_readout_port_tb.sv ----
`timescale 1ns/100ps
`include "bdr_consts.vh"
`define CHK(g, e) begin checks = checks + 1; if ((g) !== (e)) begin \
    mismatches = mismatches + 1; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module bdr_readout_port_tb;
    reg         clk_sys;
    reg         rst;
    reg  [4:0]  avs_address;
    reg         avs_read;
    reg         avs_write;
    reg  [31:0] avs_writedata;
    reg  [11:0] core_count;
    reg         core_negative;
    reg         core_over;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    wire        conversion_go;
    wire        digit_select_latch_en;
    wire [1:0]  digit_addr;
    wire [3:0]  digit_data;
    wire        sign_pos;
    wire        range_exceeded;
    wire        conversion_done;
    integer     mismatches;
    integer     checks;
    integer     i;
    reg  [31:0] rd;
    reg  [15:0] dv;
    reg         ok;
    bdr_readout_port #(.CONV_CYCLES(40)) i_dut (.clk_sys(clk_sys), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .core_count(core_count), .core_negative(core_negative), .core_over(core_over),
        .conversion_go(conversion_go), .digit_select_latch_en(digit_select_latch_en),
        .digit_addr(digit_addr), .digit_data(digit_data), .sign_pos(sign_pos),
        .range_exceeded(range_exceeded), .conversion_done(conversion_done));
    bdr_host_model i_host (.clk_sys(clk_sys), .conversion_done(conversion_done),
        .digit_data(digit_data), .conversion_go(conversion_go),
        .digit_select_latch_en(digit_select_latch_en), .digit_addr(digit_addr));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task bus(input wr, input [4:0] a, input [31:0] wd, output [31:0] d);
        integer n;
        begin
            avs_address <= a;
            avs_write <= wr;
            avs_read <= ~wr;
            avs_writedata <= wd;
            n = 0;
            @(posedge clk_sys);
            while (avs_waitrequest !== 1'b0 && n < 20) begin
                @(posedge clk_sys);
                n = n + 1;
            end
            `CHK(n < 20, 1'b1)
            d = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", checks, mismatches);
            if (mismatches == 0 && checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        #1000000;
        mismatches = mismatches + 1;
        finish_test;
    end
    initial begin
        rst = 1'b1;
        {avs_address, avs_read, avs_write, avs_writedata} = 39'h0;
        {core_count, core_negative, core_over} = 14'h0;
        mismatches = 0;
        checks = 0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        `CHK({digit_data, sign_pos, range_exceeded, conversion_done}, 7'h04)
        bus(1'b0, `BDR_OFS_STATUS, 32'h0, rd);
        `CHK(rd, 32'h2)
        bus(1'b0, 5'h18, 32'h0, rd);
        `CHK(rd, 32'h0)
        $display("test reset done");
        core_count <= 12'd1999;
        core_negative <= 1'b1;
        i_host.start;
        `CHK(conversion_done, 1'b0)
        i_host.wait_done(ok);
        `CHK(ok, 1'b1)
        i_host.read_digits(dv);
        `CHK(dv, 16'h1999)
        `CHK(sign_pos, 1'b0)
        bus(1'b0, `BDR_OFS_DIGIT4, 32'h0, rd);
        `CHK(rd, 32'h1)
        i_host.pins(1'b0, 1'b1, 2'd3);
        i_host.pins(1'b0, 1'b1, 2'd0);
        `CHK(digit_data, 4'h1)
        i_host.pins(1'b0, 1'b0, 2'd0);
        `CHK(digit_data, 4'h9)
        $display("test negative and latch done");
        for (i = 0; i < 2; i = i + 1) begin
            core_count <= i[0] ? 12'd5 : 12'd2000;
            core_over <= i[0];
            core_negative <= 1'b0;
            bus(1'b1, `BDR_OFS_CTRL, 32'h1, rd);
            `CHK(conversion_done, 1'b0)
            bus(1'b0, `BDR_OFS_STATUS, 32'h0, rd);
            `CHK(rd, i[0] ? 32'he : 32'h8)
            i_host.wait_done(ok);
            `CHK(ok, 1'b1)
            i_host.read_digits(dv);
            `CHK(dv, 16'heeee)
            `CHK(range_exceeded, 1'b1)
            bus(1'b0, `BDR_OFS_DIGIT4, 32'h0, rd);
            `CHK(rd, 32'h6e)
        end
        $display("test overrange done");
        core_over <= 1'b0;
        core_count <= 12'd42;
        i_host.pins(1'b1, 1'b0, 2'd0);
        `CHK(conversion_done, 1'b0)
        i_host.wait_done(ok);
        `CHK(ok, 1'b1)
        i_host.read_digits(dv);
        `CHK(dv, 16'h0042)
        `CHK(range_exceeded, 1'b0)
        core_count <= 12'd7;
        repeat (100) @(posedge clk_sys);
        `CHK(conversion_done, 1'b1)
        i_host.read_digits(dv);
        `CHK(dv, 16'h0007)
        i_host.pins(1'b0, 1'b0, 2'd0);
        core_count <= 12'd5;
        repeat (100) @(posedge clk_sys);
        i_host.read_digits(dv);
        `CHK(dv, 16'h0007)
        `CHK(conversion_done, 1'b1)
        i_host.start;
        i_host.wait_done(ok);
        `CHK(ok, 1'b1)
        i_host.read_digits(dv);
        `CHK(dv, 16'h0005)
        core_count <= 12'd3;
        bus(1'b1, `BDR_OFS_CTRL, 32'h2, rd);
        bus(1'b0, `BDR_OFS_CTRL, 32'h0, rd);
        `CHK(rd, 32'h2)
        repeat (100) @(posedge clk_sys);
        i_host.read_digits(dv);
        `CHK(dv, 16'h0003)
        `CHK(conversion_done, 1'b1)
        bus(1'b1, `BDR_OFS_CTRL, 32'h0, rd);
        $display("test continuous done");
        finish_test;
    end
endmodule
bind bdr_readout_port bdr_readout_port_sva i_sva (.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .conversion_go(conversion_go), .digit_data(digit_data),
    .range_exceeded(range_exceeded), .conversion_done(conversion_done));
